// ### design/crc_calculator_regs.vh
`ifndef CRC_CALCULATOR_REGS_VH
`define CRC_CALCULATOR_REGS_VH

// register byte offsets on the APB
`define CRC_CONTROL_OFFSET 12'h000
`define CRC_DATA_IN_OFFSET 12'h004
`define CRC_DATA_OUT_OFFSET 12'h008

// control register field positions
`define CRC_POLY_SELECT_LSB 0
`define CRC_POLY_SELECT_MSB 2
`define CRC_BIT_ORDER_SELECT_BIT 6
`define CRC_MODULE_STOP_BIT 7

// reset values
`define CRC_CONTROL_RESET 8'h00
`define CRC_DATA_IN_RESET 32'h00000000
`define CRC_DATA_OUT_RESET 32'h00000000

// polynomial select codes
`define CRC_SEL_NONE 3'h0
`define CRC_SEL_CRC8 3'h1
`define CRC_SEL_CRC16_A 3'h2
`define CRC_SEL_CRC16_B 3'h3
`define CRC_SEL_CRC32_A 3'h4
`define CRC_SEL_CRC32_B 3'h5
`define CRC_SEL_RSVD_6 3'h6
`define CRC_SEL_RSVD_7 3'h7

// generating polynomials, top term implied
`define CRC_POLY_CRC8 8'h07
`define CRC_POLY_CRC16_A 16'h8005
`define CRC_POLY_CRC16_B 16'h1021
`define CRC_POLY_CRC32_A 32'h04C11DB7
`define CRC_POLY_CRC32_B 32'h1EDC6F41

// access timing: wait states inserted before the answer
`define CRC_APB_WAIT_CYCLES 0

`endif

// ### design/crc_step.v
// one parallel fold of a data word into a running code
module crc_step #(
    parameter WIDTH = 8,
    parameter DBITS = 8,
    parameter [WIDTH-1:0] POLY = 8'h07
) (
    input wire [WIDTH-1:0] crc_in,
    input wire [DBITS-1:0] data,
    input wire msb_first,
    output reg [WIDTH-1:0] crc_out
);
    wire [WIDTH-1:0] rpoly;
    reg fb;
    integer i;
    genvar g;

    // reflected polynomial for the lsb-first form; constant, so wired,
    // since a process reading only constants would never wake
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : reflect
            assign rpoly[g] = POLY[WIDTH-1-g];
        end
    endgenerate

    // unrolled bit loop, the whole word folds in a single cycle
    always @*
    begin
        crc_out = crc_in;
        fb = 1'b0;
        for (i = 0; i < DBITS; i = i + 1)
        begin
            if (msb_first)
            begin
                fb = crc_out[WIDTH-1] ^ data[DBITS-1-i];
                crc_out = {crc_out[WIDTH-2:0], 1'b0} ^ (fb ? POLY : {WIDTH{1'b0}});
            end
            else
            begin
                fb = crc_out[0] ^ data[i];
                crc_out = {1'b0, crc_out[WIDTH-1:1]} ^ (fb ? rpoly : {WIDTH{1'b0}});
            end
        end
    end
endmodule // crc_step

// ### design/lane_pick.v
// picks the lowest enabled byte lane of a 32-bit write
module lane_pick (
    input wire [31:0] wdata,
    input wire [3:0] strb,
    output reg [7:0] byte_out,
    output reg any_lane
);
    // lowest lane wins when software strobes more than one
    always @*
    begin
        any_lane = |strb;
        if (strb[0])
            byte_out = wdata[7:0];
        else if (strb[1])
            byte_out = wdata[15:8];
        else if (strb[2])
            byte_out = wdata[23:16];
        else
            byte_out = wdata[31:24];
    end
endmodule // lane_pick

// ### design/crc_calculator.v
// Functional notes
// - three-bit field selects the five polynomials
// - select code 000 disables calculation
// - codes 110 and 111 reserved, no calculation
// - narrow polynomials: one 8-bit, two 16-bit
// - two 32-bit polynomials offered
// - narrow modes fold one byte per write
// - wide modes fold one longword per write
// - control bit picks lsb or msb order
// - bit-order control sits at bit 6
// - 8-bit code kept in low byte
// - module stop halts the calculator
//
// Implementation choices: the register addresses and the APB slave port.
`include "crc_calculator_regs.vh"

module crc_calculator #(
    parameter ADDR_WIDTH = 12
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr
);
    // register state
    reg [7:0] control_r;
    reg [7:0] control_nxt;
    reg [31:0] data_in_r;
    reg [31:0] data_in_nxt;
    reg [31:0] data_out_r;
    reg [31:0] data_out_nxt;
    reg [31:0] rdata_nxt;
    reg slverr_nxt;

    // control fields
    wire [2:0] poly_select;
    wire bit_order_select;
    wire module_stop;

    // bus phase decode
    wire setup_phase;
    wire write_access;
    reg hit_control;
    reg hit_data_in;
    reg hit_data_out;
    wire hit_any;

    // mode decode
    wire mode_crc8;
    wire mode_crc16_a;
    wire mode_crc16_b;
    wire mode_crc32_a;
    wire mode_crc32_b;
    wire mode_narrow;
    wire mode_wide;
    wire calc_enabled;
    wire code_idle;
    wire code_reserved;

    // input byte and fold results
    wire [7:0] in_byte;
    wire in_byte_valid;
    wire [7:0] fold8;
    wire [15:0] fold16_a;
    wire [15:0] fold16_b;
    wire [31:0] fold32_a;
    wire [31:0] fold32_b;
    reg [31:0] fold_result;
    wire full_word;
    wire [31:0] lane_mask;
    reg [31:0] data_out_view;

    // per-register write strobes and fold decisions
    wire write_control;
    wire write_data_in;
    wire write_data_out;
    wire fold_narrow;
    wire fold_wide;

    // control register fields
    assign poly_select = control_r[`CRC_POLY_SELECT_MSB:`CRC_POLY_SELECT_LSB];
    assign bit_order_select = control_r[`CRC_BIT_ORDER_SELECT_BIT];
    assign module_stop = control_r[`CRC_MODULE_STOP_BIT];

    // one-hot view of the select field
    assign mode_crc8 = (poly_select == `CRC_SEL_CRC8);
    assign mode_crc16_a = (poly_select == `CRC_SEL_CRC16_A);
    assign mode_crc16_b = (poly_select == `CRC_SEL_CRC16_B);
    assign mode_crc32_a = (poly_select == `CRC_SEL_CRC32_A);
    assign mode_crc32_b = (poly_select == `CRC_SEL_CRC32_B);
    assign mode_narrow = mode_crc8 | mode_crc16_a | mode_crc16_b;
    assign mode_wide = mode_crc32_a | mode_crc32_b;

    // codes 000, 110 and 111 fall out of both groups: no fold at all
    assign code_idle = (poly_select == `CRC_SEL_NONE);
    assign code_reserved = (poly_select == `CRC_SEL_RSVD_6) |
        (poly_select == `CRC_SEL_RSVD_7);
    assign calc_enabled = ~code_idle & ~code_reserved & ~module_stop;

    // apb phases; the slave never inserts wait states
    assign setup_phase = psel & ~penable;
    assign write_access = psel & penable & pwrite;
    assign pready = 1'b1;

    // address decode on aligned words only; other offsets answer with an error
    always @*
    begin
        hit_control = 1'b0;
        hit_data_in = 1'b0;
        hit_data_out = 1'b0;
        case (paddr)
            `CRC_CONTROL_OFFSET: hit_control = 1'b1;
            `CRC_DATA_IN_OFFSET: hit_data_in = 1'b1;
            `CRC_DATA_OUT_OFFSET: hit_data_out = 1'b1;
            default: hit_control = 1'b0;
        endcase
    end

    // any mapped register
    assign hit_any = hit_control | hit_data_in | hit_data_out;

    // a longword fold needs all four lanes, partial writes would corrupt it
    assign full_word = (pstrb == 4'hF);

    // one write strobe per register; a stopped module drops data writes
    assign write_control = write_access & hit_control & pstrb[0];
    assign write_data_in = write_access & hit_data_in & ~module_stop;
    assign write_data_out = write_access & hit_data_out & ~module_stop;

    // a fold needs a write that fits the width of the active code
    assign fold_narrow = calc_enabled & mode_narrow & in_byte_valid;
    assign fold_wide = calc_enabled & mode_wide & full_word;

    // byte selection for the narrow modes
    lane_pick u_lane_pick (
        .wdata(pwdata),
        .strb(pstrb),
        .byte_out(in_byte),
        .any_lane(in_byte_valid)
    );

    // 8-bit polynomial, byte in parallel
    crc_step #(
        .WIDTH(8),
        .DBITS(8),
        .POLY(`CRC_POLY_CRC8)
    ) u_step8 (
        .crc_in(data_out_r[7:0]),
        .data(in_byte),
        .msb_first(bit_order_select),
        .crc_out(fold8)
    );

    // first 16-bit polynomial, byte in parallel
    crc_step #(
        .WIDTH(16),
        .DBITS(8),
        .POLY(`CRC_POLY_CRC16_A)
    ) u_step16_a (
        .crc_in(data_out_r[15:0]),
        .data(in_byte),
        .msb_first(bit_order_select),
        .crc_out(fold16_a)
    );

    // second 16-bit polynomial, byte in parallel
    crc_step #(
        .WIDTH(16),
        .DBITS(8),
        .POLY(`CRC_POLY_CRC16_B)
    ) u_step16_b (
        .crc_in(data_out_r[15:0]),
        .data(in_byte),
        .msb_first(bit_order_select),
        .crc_out(fold16_b)
    );

    // first 32-bit polynomial, longword in parallel
    crc_step #(
        .WIDTH(32),
        .DBITS(32),
        .POLY(`CRC_POLY_CRC32_A)
    ) u_step32_a (
        .crc_in(data_out_r),
        .data(pwdata),
        .msb_first(bit_order_select),
        .crc_out(fold32_a)
    );

    // second 32-bit polynomial, longword in parallel
    crc_step #(
        .WIDTH(32),
        .DBITS(32),
        .POLY(`CRC_POLY_CRC32_B)
    ) u_step32_b (
        .crc_in(data_out_r),
        .data(pwdata),
        .msb_first(bit_order_select),
        .crc_out(fold32_b)
    );

    // result of the selected fold; narrow codes keep upper bits clear
    always @*
    begin
        case (poly_select)
            `CRC_SEL_CRC8: fold_result = {24'h000000, fold8};
            `CRC_SEL_CRC16_A: fold_result = {16'h0000, fold16_a};
            `CRC_SEL_CRC16_B: fold_result = {16'h0000, fold16_b};
            `CRC_SEL_CRC32_A: fold_result = fold32_a;
            `CRC_SEL_CRC32_B: fold_result = fold32_b;
            default: fold_result = data_out_r;
        endcase
    end

    // byte-lane mask for data input writes and for writes that seed the code
    assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // read view of the code, trimmed to the width of the active code
    always @*
    begin
        case (poly_select)
            `CRC_SEL_CRC8: data_out_view = {24'h000000, data_out_r[7:0]};
            `CRC_SEL_CRC16_A: data_out_view = {16'h0000, data_out_r[15:0]};
            `CRC_SEL_CRC16_B: data_out_view = {16'h0000, data_out_r[15:0]};
            default: data_out_view = data_out_r;
        endcase
    end

    // control register writes; only the defined fields are kept
    always @*
    begin
        control_nxt = control_r;
        if (write_control)
        begin
            control_nxt = 8'h00;
            control_nxt[`CRC_POLY_SELECT_MSB:`CRC_POLY_SELECT_LSB] =
                pwdata[`CRC_POLY_SELECT_MSB:`CRC_POLY_SELECT_LSB];
            control_nxt[`CRC_BIT_ORDER_SELECT_BIT] = pwdata[`CRC_BIT_ORDER_SELECT_BIT];
            control_nxt[`CRC_MODULE_STOP_BIT] = pwdata[`CRC_MODULE_STOP_BIT];
        end
    end

    // data input: stores the written value and folds it into the code
    always @*
    begin
        data_in_nxt = data_in_r;
        data_out_nxt = data_out_r;
        if (write_data_in)
        begin
            data_in_nxt = (data_in_r & ~lane_mask) | (pwdata & lane_mask);
            if (fold_narrow)
                data_out_nxt = fold_result;
            else if (fold_wide)
                data_out_nxt = fold_result;
        end
        else if (write_data_out)
        begin
            // seeding loads only the strobed lanes
            data_out_nxt = (data_out_r & ~lane_mask) | (pwdata & lane_mask);
        end
    end

    // read data and error captured in setup, so they sit in flops at access
    always @*
    begin
        rdata_nxt = prdata;
        slverr_nxt = pslverr;
        if (setup_phase)
        begin
            slverr_nxt = ~hit_any;
            if (pwrite || !hit_any)
                rdata_nxt = 32'h00000000;
            else if (hit_control)
                rdata_nxt = {24'h000000, control_r};
            else if (hit_data_in)
                rdata_nxt = data_in_r;
            else
                rdata_nxt = data_out_view;
        end
    end

    // control register; clears to lsb order, no calculation, running
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control_r <= `CRC_CONTROL_RESET;
        end
        else
        begin
            control_r <= control_nxt;
        end
    end

    // last value written to the data input
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_in_r <= `CRC_DATA_IN_RESET;
        end
        else
        begin
            data_in_r <= data_in_nxt;
        end
    end

    // running code; software seeds it before a run and reads it after
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_out_r <= `CRC_DATA_OUT_RESET;
        end
        else
        begin
            data_out_r <= data_out_nxt;
        end
    end

    // bus answer flops, so read data stands steady through the access phase
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata <= rdata_nxt;
            pslverr <= slverr_nxt;
        end
    end
endmodule // crc_calculator

// ### verification/crc_calculator_checker.sv
`include "crc_calculator_regs.vh"
module crc_calculator_checker #(
    parameter ADDR_WIDTH = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic [7:0] ctrl_r;
    wire setup = psel && !penable;
    wire rd_ctl = setup && !pwrite && paddr == `CRC_CONTROL_OFFSET;
    wire rd_out = setup && !pwrite && paddr == `CRC_DATA_OUT_OFFSET;
    wire mapped = paddr == `CRC_CONTROL_OFFSET || paddr == `CRC_DATA_IN_OFFSET
        || paddr == `CRC_DATA_OUT_OFFSET;
    // shadow of the control byte; unused bits never stored
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_r <= 8'h00;
        else if (psel && penable && pwrite && pstrb[0] && paddr == `CRC_CONTROL_OFFSET)
            ctrl_r <= pwdata[7:0] & 8'hC7;
    end
    no_wait_a: assert property (pready) else $error("pready low");
    err_unmapped_a: assert property (setup && !mapped |=> pslverr)
        else $error("no error on unmapped address");
    err_mapped_a: assert property (setup && mapped |=> !pslverr) else $error("spurious error");
    unmapped_zero_a: assert property (setup && !pwrite && !mapped |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!psel |=> $stable(prdata)) else $error("prdata moved");
    ctrl_read_a: assert property (rd_ctl |=> prdata == {24'h0, ctrl_r})
        else $error("control readback wrong");
    byte_view_a: assert property (rd_out && ctrl_r[2:0] == 3'h1 |=> prdata[31:8] == 24'h0)
        else $error("8-bit code not in low byte");
    word_view_a: assert property (rd_out && ctrl_r[2:1] == 2'h1 |=> prdata[31:16] == 16'h0)
        else $error("16-bit code upper half set");
    cover property (setup && !mapped);
    cover property (rd_out && ctrl_r[2:0] == 3'h1);
    cover property (rd_out && ctrl_r[7]);
endmodule // crc_calculator_checker

bind crc_calculator crc_calculator_checker #(.ADDR_WIDTH(ADDR_WIDTH)) chk (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr);

// ### verification/test_crc_calculator.sv
`include "crc_calculator_regs.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module test_crc_calculator;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, exp, d;
    logic [3:0] pstrb = 4'h0, s;
    wire pready, pslverr;
    wire [31:0] prdata;
    int error_cnt = 0, checked = 0;
    crc_calculator uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .pready, .prdata, .pslverr);
    initial forever #50 pclk = ~pclk;
    // one apb transfer; request held until pready is seen
    task bus(input logic w, input logic [11:0] a, input logic [31:0] v, input logic [3:0] b);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, v, b};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // bitwise reference fold, msb or reflected lsb order
    function automatic logic [31:0] fold(logic [2:0] m, logic o, logic [31:0] c,
        logic [31:0] v, int n);
        int w;
        logic [31:0] p, r, k;
        logic fb;
        case (m)
            3'h1: begin w = 8; p = `CRC_POLY_CRC8; end
            3'h2: begin w = 16; p = `CRC_POLY_CRC16_A; end
            3'h3: begin w = 16; p = `CRC_POLY_CRC16_B; end
            3'h4: begin w = 32; p = `CRC_POLY_CRC32_A; end
            3'h5: begin w = 32; p = `CRC_POLY_CRC32_B; end
            default: return c;
        endcase
        k = (32'h1 << w) - 32'h1;
        r = 32'h0;
        for (int i = 0; i < w; i++) r[w-1-i] = p[i];
        c = c & k;
        for (int i = 0; i < n; i++)
        begin
            fb = o ? c[w-1] ^ v[n-1-i] : c[0] ^ v[i];
            c = o ? ((c << 1) ^ (fb ? p : 32'h0)) & k : (c >> 1) ^ (fb ? r : 32'h0);
        end
        return c;
    endfunction
    task tally_and_finish;
        $display("errors=%0d checks=%0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // hang guard, far beyond the 164 transfers
    initial
    begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        tally_and_finish;
    end
    initial
    begin
        void'($urandom(32'h85FB));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 12; a += 4)
        begin
            bus(0, a[11:0], 32'h0, 4'h0);
            `CHK({err, rd}, 33'h0)
        end
        bus(1, 12'h000, 32'hFF, 4'hF);
        bus(1, 12'h000, 32'h00, 4'hE);
        bus(0, 12'h000, 32'h0, 4'h0);
        `CHK(rd, 32'hC7)
        bus(1, 12'h00C, 32'hFFFFFFFF, 4'hF);
        bus(0, 12'h00C, 32'h0, 4'h0);
        `CHK({err, rd}, 33'h100000000)
        // every select code in both orders, random lanes and seeds
        for (int m = 0; m < 8; m++)
            for (int o = 0; o < 2; o++)
            begin
                bus(1, 12'h000, {25'h0, o[0], 3'h0, m[2:0]}, 4'hF);
                exp = $urandom;
                bus(1, 12'h008, exp, 4'hF);
                repeat (6)
                begin
                    d = $urandom;
                    s = m > 3 ? ($urandom % 2 ? 4'hF : 4'($urandom)) : 4'h1 << ($urandom % 4);
                    bus(1, 12'h004, d, s);
                    if (m > 3 && s == 4'hF)
                        exp = fold(m[2:0], o[0], exp, d, 32);
                    if (m < 4 && s != 4'h0)
                        exp = fold(m[2:0], o[0], exp, d >> (s[0] ? 0 : s[1] ? 8 : s[2] ? 16 : 24), 8);
                end
                bus(0, 12'h008, 32'h0, 4'h0);
                d = m == 1 ? 32'hFF : m == 2 || m == 3 ? 32'hFFFF : 32'hFFFFFFFF;
                `CHK(rd, exp & d)
            end
        bus(1, 12'h004, 32'h1234ABCD, 4'hF);
        bus(0, 12'h004, 32'h0, 4'h0);
        `CHK(rd, 32'h1234ABCD)
        // stopped module ignores data writes, then runs again
        bus(1, 12'h000, 32'h04, 4'hF);
        bus(1, 12'h008, 32'h13579BDF, 4'hF);
        bus(1, 12'h000, 32'h84, 4'hF);
        bus(1, 12'h004, 32'hFFFFFFFF, 4'hF);
        bus(1, 12'h008, 32'h0, 4'hF);
        bus(0, 12'h008, 32'h0, 4'h0);
        `CHK(rd, 32'h13579BDF)
        bus(1, 12'h000, 32'h04, 4'hF);
        bus(1, 12'h004, 32'hFFFFFFFF, 4'hF);
        bus(0, 12'h008, 32'h0, 4'h0);
        `CHK(rd, fold(3'h4, 1'b0, 32'h13579BDF, 32'hFFFFFFFF, 32))
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        bus(0, 12'h000, 32'h0, 4'h0);
        `CHK(rd, 32'h0)
        tally_and_finish;
    end
endmodule // test_crc_calculator
